/* ioexp_pkg.sv */
// Shared constants and types for the 16-bit I/O expander slave block.
// Assumes one 25 MHz system clock and a synchronous active-high reset.
package ioexp_pkg;
    // =========================================================
    // Register indices (command byte values)
    localparam logic [2:0] REG_IN0 = 3'h0; // Input port 0
    localparam logic [2:0] REG_OUT0 = 3'h2; // Output port 0
    localparam logic [2:0] REG_POL0 = 3'h4; // Polarity port 0
    localparam logic [2:0] REG_CFG0 = 3'h6; // Direction port 0
    // Pair select field in the pointer
    localparam logic [1:0] PAIR_IN = 2'h0;
    localparam logic [1:0] PAIR_OUT = 2'h1;
    localparam logic [1:0] PAIR_POL = 2'h2;
    // =========================================================
    // Reset values
    localparam logic [15:0] OUT_RST = 16'hFFFF;
    localparam logic [15:0] POL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'hFFFF;
    localparam logic [2:0] PTR_RST = 3'h0;
    // =========================================================
    // Bus framing
    localparam logic [3:0] BYTE_BITS = 4'h8; // Bits per byte
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam int FIFO_DEPTH = 16; // Write buffer entries
    localparam int FIFO_WIDTH = 11; // Pointer plus data byte
    // =========================================================
    // Slave state machine
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_WR = 3'b011,
        ST_ACK_WR = 3'b100,
        ST_RD = 3'b101,
        ST_ACK_RD = 3'b110
    } slv_state_t;
endpackage

/* ioexp_core.sv */
// I2C slave access, register pairs, write buffer and change interrupt.
// Assumes SCL, SDA and port pins are asynchronous and the bench resolves
// open-drain wires from the output enables.
`timescale 1ns/1ps

// =============================================================
// Write buffer FIFO
module ioexp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_srst, // Synchronous reset
    input wire logic i_in_valid, // Push request
    output logic o_in_ready, // Not full
    input wire logic [WIDTH-1:0] i_in_data, // Push data
    output logic o_out_valid, // Not empty
    input wire logic i_out_ready, // Pop request
    output logic [WIDTH-1:0] o_out_data // Head entry
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
    logic [AW:0] wptr_ff; // Write pointer, extra wrap bit
    logic [AW:0] rptr_ff; // Read pointer, extra wrap bit
    wire full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    wire empty = (wptr_ff == rptr_ff);
    wire do_push = i_in_valid && !full;
    wire do_pop = i_out_ready && !empty;
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_ff[rptr_ff[AW-1:0]];

    // Pointers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            if (do_push) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
        end
    end

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge i_clk_sys) begin
        if (do_push) begin
            mem_ff[wptr_ff[AW-1:0]] <= i_in_data;
        end
    end
endmodule // ioexp_fifo

// =============================================================
// Top: I2C slave and port logic
module ioexp_core
    import ioexp_pkg::*;
#(
    parameter logic [3:0] ADDR_HI = 4'h4, // Fixed address bits, arbitrary value
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk_sys, // 25 MHz system clock
    input wire logic i_srst, // Synchronous reset, high
    input wire logic [2:0] i_addr_sel, // Address select straps
    input wire logic i_scl, // Bus clock pin
    input wire logic i_sda, // Bus data pin level
    output logic o_sda, // Bus data drive value, always 0
    output logic o_sda_oe_n, // Low while pulling SDA low
    input wire logic [15:0] i_pin, // Port pin levels
    output logic [15:0] o_pin, // Port pin drive values
    output logic [15:0] o_pin_oe_n, // Low while pin driven
    output logic o_int, // Interrupt drive value, always 0
    output logic o_int_oe_n, // Low while interrupt asserted
    input wire logic i_wr_hold // Stall register updates
);
    // =========================================================
    // Synchronisers: first stage feeds only the second
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic [15:0] pin_s1_ff, pin_s2_ff;

    always_ff @(posedge i_clk_sys) begin
        scl_s1_ff <= i_scl;
        scl_s2_ff <= scl_s1_ff;
        scl_d_ff <= scl_s2_ff;
        sda_s1_ff <= i_sda;
        sda_s2_ff <= sda_s1_ff;
        sda_d_ff <= sda_s2_ff;
        pin_s1_ff <= i_pin;
        pin_s2_ff <= pin_s1_ff;
    end

    // Bus events
    wire scl_rise = scl_s2_ff && !scl_d_ff;
    wire scl_fall = !scl_s2_ff && scl_d_ff;
    wire bus_start = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
    wire bus_stop = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;

    // =========================================================
    // Register state
    logic [15:0] out_ff; // Output port pair
    logic [15:0] pol_ff; // Polarity pair
    logic [15:0] cfg_ff; // Direction pair, 1 = input
    logic [15:0] snap_ff; // Input value at last read
    logic int_oe_n_ff; // Registered interrupt drive

    // Input register: live pins whatever the direction
    wire [15:0] in_val = pin_s2_ff ^ pol_ff;

    // =========================================================
    // Slave machine registers
    slv_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt; // Bit counter
    logic [7:0] sh_ff, nxt_sh; // Receive shifter
    logic [7:0] tx_ff, nxt_tx; // Transmit shifter
    logic [2:0] ptr_ff, nxt_ptr; // Register pointer
    logic cmd_ff, nxt_cmd; // Command byte taken
    logic rw_ff, nxt_rw; // Direction bit of address
    logic mack_ff, nxt_mack; // Master acknowledged last byte
    logic sda_oe_n_ff, nxt_sda_oe_n; // SDA drive
    logic push; // Write byte into buffer
    logic snap_en; // Read of a byte completed

    // Read data selection from the pointer
    wire [15:0] rd_word = (ptr_ff[2:1] == PAIR_IN) ? in_val :
                          (ptr_ff[2:1] == PAIR_OUT) ? out_ff :
                          (ptr_ff[2:1] == PAIR_POL) ? pol_ff : cfg_ff;
    wire [7:0] rd_byte = ptr_ff[0] ? rd_word[15:8] : rd_word[7:0];
    wire addr_hit = (sh_ff[7:1] == {ADDR_HI, i_addr_sel});

    // FIFO wires
    logic fifo_in_ready, fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;
    wire fifo_pop = fifo_out_valid && !i_wr_hold;
    wire [2:0] wr_ptr = fifo_out_data[10:8];
    wire [7:0] wr_byte = fifo_out_data[7:0];

    // =========================================================
    // Next state of the slave machine
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_cmd = cmd_ff;
        nxt_rw = rw_ff;
        nxt_mack = mack_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        push = 1'b0;
        snap_en = 1'b0;
        if (bus_start) begin
            // Start or repeated start; pointer is kept across it
            nxt_state = ST_ADDR;
            nxt_cnt = CNT_RST;
            nxt_cmd = 1'b0;
            nxt_sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            nxt_state = ST_IDLE;
            nxt_sda_oe_n = 1'b1;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    nxt_sda_oe_n = 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[6:0], sda_s2_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == BYTE_BITS) begin
                        nxt_cnt = CNT_RST;
                        if (addr_hit) begin
                            nxt_state = ST_ACK_ADDR;
                            nxt_rw = sh_ff[0];
                            nxt_sda_oe_n = 1'b0;
                        end else begin
                            // Other slave addressed: wait for next start
                            nxt_state = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall && rw_ff) begin
                        // Load selected register at ACK falling edge
                        nxt_state = ST_RD;
                        nxt_tx = rd_byte;
                        nxt_sda_oe_n = rd_byte[7];
                        nxt_cnt = CNT_RST;
                    end else if (scl_fall) begin
                        nxt_state = ST_WR;
                        nxt_sda_oe_n = 1'b1;
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[6:0], sda_s2_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == BYTE_BITS) begin
                        nxt_cnt = CNT_RST;
                        nxt_state = ST_ACK_WR;
                        if (!cmd_ff) begin
                            // First byte is the command
                            nxt_ptr = sh_ff[2:0];
                            nxt_cmd = 1'b1;
                            nxt_sda_oe_n = 1'b0;
                        end else if (fifo_in_ready) begin
                            // Unlimited data bytes, alternating in the pair
                            push = 1'b1;
                            nxt_ptr = {ptr_ff[2:1], ~ptr_ff[0]};
                            nxt_sda_oe_n = 1'b0;
                        end
                        // Full buffer: byte not acknowledged, pointer kept
                    end
                end
                ST_ACK_WR: begin
                    if (scl_fall) begin
                        nxt_state = ST_WR;
                        nxt_sda_oe_n = 1'b1;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == BYTE_BITS) begin
                        nxt_state = ST_ACK_RD;
                        nxt_sda_oe_n = 1'b1;
                        nxt_cnt = CNT_RST;
                    end else if (scl_fall) begin
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        nxt_sda_oe_n = tx_ff[6];
                    end
                end
                ST_ACK_RD: begin
                    if (scl_rise) begin
                        // ACK or NACK bit: clear and step to the partner
                        nxt_mack = !sda_s2_ff;
                        snap_en = 1'b1;
                        nxt_ptr = {ptr_ff[2:1], ~ptr_ff[0]};
                    end else if (scl_fall && mack_ff) begin
                        nxt_state = ST_RD;
                        nxt_tx = rd_byte;
                        nxt_sda_oe_n = rd_byte[7];
                    end else if (scl_fall) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // Slave machine registers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_RST;
            sh_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= PTR_RST;
            cmd_ff <= 1'b0;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            cmd_ff <= nxt_cmd;
            rw_ff <= nxt_rw;
            mack_ff <= nxt_mack;
            sda_oe_n_ff <= nxt_sda_oe_n;
        end
    end

    // =========================================================
    // Write buffer decouples bus bytes from register updates
    ioexp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_in_valid(push),
        .o_in_ready(fifo_in_ready),
        .i_in_data({ptr_ff, sh_ff}),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(!i_wr_hold),
        .o_out_data(fifo_out_data)
    );

    // Register writes; input pair is read only
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            out_ff <= OUT_RST;
            pol_ff <= POL_RST;
            cfg_ff <= CFG_RST;
        end else if (fifo_pop) begin
            if (wr_ptr == REG_OUT0) out_ff[7:0] <= wr_byte;
            if (wr_ptr == (REG_OUT0 | 3'h1)) out_ff[15:8] <= wr_byte;
            if (wr_ptr == REG_POL0) pol_ff[7:0] <= wr_byte;
            if (wr_ptr == (REG_POL0 | 3'h1)) pol_ff[15:8] <= wr_byte;
            if (wr_ptr == REG_CFG0) cfg_ff[7:0] <= wr_byte;
            if (wr_ptr == (REG_CFG0 | 3'h1)) cfg_ff[15:8] <= wr_byte;
        end
    end

    // =========================================================
    // Change detect: snapshot of each input port at its read.
    // A pin edge after the byte is loaded and before the ACK clock rise lands in the snapshot and is lost.
    wire snap_lo = snap_en && ptr_ff == REG_IN0;
    wire snap_hi = snap_en && ptr_ff == (REG_IN0 | 3'h1);
    wire int_any = |(cfg_ff & (in_val ^ snap_ff));

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            snap_ff <= in_val;
            int_oe_n_ff <= 1'b1;
        end else begin
            if (snap_lo) snap_ff[7:0] <= in_val[7:0];
            if (snap_hi) snap_ff[15:8] <= in_val[15:8];
            int_oe_n_ff <= !int_any;
        end
    end

    // =========================================================
    // Pin drive
    assign o_sda = 1'b0;
    assign o_sda_oe_n = sda_oe_n_ff;
    assign o_int = 1'b0;
    assign o_int_oe_n = int_oe_n_ff;
    assign o_pin = out_ff;
    assign o_pin_oe_n = cfg_ff;
endmodule // ioexp_core

/* i2c_host_model.sv */
// Bus master model: drives SCL and pulls SDA low, one bit at a time.
// Assumes the bench resolves SDA with a pull-up from every enable.
`timescale 1ns/1ps

// ==========
// Bus master
module i2c_host_model (
    input wire logic i_clk_sys, // Pacing clock
    input wire logic i_sda, // Resolved SDA level
    output logic o_scl, // SCL, idles high
    output logic o_sda_oe_n // Low while pulling SDA
);
    // SCL stands still high between frames
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // One bit of 8 clocks (320 ns); SDA moves only in the low half
    task automatic bit_io(input logic b, output logic r);
        o_scl <= 1'b0;
        tick(2);
        o_sda_oe_n <= b;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        r = i_sda;
    endtask
    // Start or repeated start, only from an idle or owned bus
    task automatic start();
        logic r;
        bit_io(1'b1, r);
        o_sda_oe_n <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        logic r;
        bit_io(1'b0, r);
        o_sda_oe_n <= 1'b1;
        tick(4);
    endtask
    // Byte out, MSB first; returns the SDA level of the ninth bit
    task automatic tx(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack_n);
    endtask
    // Byte in; the last byte of a read is refused
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule // i2c_host_model

/* ioexp_core_chk.sv */
// Port checker for the expander: bus drive timing, interrupt, reset.
// Bound to ioexp_core; sees only its ports.
`timescale 1ns/1ps

// =======
// Checker
module ioexp_core_chk
    import ioexp_pkg::*;
(
    input wire logic i_clk_sys, // Clock
    input wire logic i_srst, // Reset
    input wire logic i_scl, // SCL level
    input wire logic [15:0] i_pin, // Pin levels
    input wire logic i_wr_hold, // Buffer stall
    input wire logic o_sda, // SDA value
    input wire logic o_sda_oe_n, // SDA pull
    input wire logic [15:0] o_pin, // Output reg
    input wire logic [15:0] o_pin_oe_n, // Direction
    input wire logic o_int, // Int value
    input wire logic o_int_oe_n // Int pull
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    logic [15:0] pin_d_ff; // Pins a clock ago
    logic scl_d_ff; // SCL a clock ago
    logic hold_d_ff; // Stall a clock ago
    logic [3:0] quiet_ff; // Clocks since a possible clear cause
    logic stir; // Pin, SCL or stall moved
    logic [3:0] nxt_quiet;
    assign stir = (i_pin != pin_d_ff) || (i_scl != scl_d_ff) || (i_wr_hold != hold_d_ff);
    assign nxt_quiet = stir ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
    // History for the clear check; saturates so it never wraps
    always_ff @(posedge i_clk_sys) begin
        pin_d_ff <= i_pin;
        scl_d_ff <= i_scl;
        hold_d_ff <= i_wr_hold;
        quiet_ff <= i_srst ? 4'h0 : nxt_quiet;
    end
    property p_reset_vals;
        $fell(i_srst) |-> o_pin == OUT_RST && o_pin_oe_n == CFG_RST && o_sda_oe_n && o_int_oe_n;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");
    property p_open_drain;
        o_sda == 1'b0 && o_int == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("drive value not low");
    property p_out_no_int;
        (o_pin_oe_n == 16'h0000) [*3] |-> o_int_oe_n;
    endproperty
    a_out_no_int: assert property (p_out_no_int) else $error("output pin interrupt");
    property p_int_raise;
        $stable(i_pin) [*4] ##1 ($changed(i_pin & o_pin_oe_n) && $stable(o_pin_oe_n)
            && o_int_oe_n) |-> ##[1:5] !o_int_oe_n;
    endproperty
    a_int_raise: assert property (p_int_raise) else $error("edge not flagged");
    property p_sda_low_phase;
        $changed(o_sda_oe_n) |-> !i_scl;
    endproperty
    a_sda_low_phase: assert property (p_sda_low_phase) else $error("SDA moved, SCL high");
    property p_sda_quiet;
        $stable(i_scl) [*8] |-> $stable(o_sda_oe_n);
    endproperty
    a_sda_quiet: assert property (p_sda_quiet) else $error("SDA moved, no clock");
    property p_hold_freeze;
        i_wr_hold [*3] |-> $stable(o_pin) && $stable(o_pin_oe_n);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("update while held");
    property p_clear_cause;
        $rose(o_int_oe_n) |-> quiet_ff < 4'hc;
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("clear without cause");
    c_ack: cover property ($fell(o_sda_oe_n));
    c_int: cover property ($fell(o_int_oe_n));
    c_clr: cover property ($rose(o_int_oe_n));
endmodule // ioexp_core_chk

bind ioexp_core ioexp_core_chk chk_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(i_scl),
    .i_pin(i_pin), .i_wr_hold(i_wr_hold), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_int(o_int), .o_int_oe_n(o_int_oe_n));

/* ioexp_core_bench.sv */
// Bench: runs the expander from a bus master model against a register model.
// Assumes ioexp_pkg, ioexp_core and i2c_host_model are compiled first.
`timescale 1ns/1ps

// =====
// Bench
module ioexp_core_bench;
    import ioexp_pkg::*;
    localparam logic [3:0] AHI = 4'h4; // Fixed address bits, arbitrary value
    localparam logic [2:0] SEL = 3'h5; // Strap value
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic i_wr_hold = 1'b0;
    logic [15:0] ext = 16'h0000; // Far side drive on input pins
    logic scl, m_oe_n, o_sda, o_sda_oe_n, o_int, o_int_oe_n, a;
    logic [15:0] o_pin, o_pin_oe_n, pin_w, old, snap;
    logic [7:0] rf [8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    logic [2:0] ptr; // Model pointer
    logic [31:0] lf = 32'h0000_418f;
    int num_errors = 0;
    int compares = 0;
    int fill = 0; // Model buffer level
    wire sda_w = m_oe_n & o_sda_oe_n; // Pull-up wire
    wire [15:0] out_m = {rf[3], rf[2]};
    wire [15:0] cfg_m = {rf[7], rf[6]};
    wire [15:0] in_m = ((cfg_m & ext) | (~cfg_m & out_m)) ^ {rf[5], rf[4]};
    // Driven pins show the output register, the rest the far side
    assign pin_w = (o_pin_oe_n & ext) | (~o_pin_oe_n & o_pin);
    always #20 i_clk_sys = ~i_clk_sys;
    i2c_host_model m (.i_clk_sys(i_clk_sys), .i_sda(sda_w), .o_scl(scl), .o_sda_oe_n(m_oe_n));
    ioexp_core #(.ADDR_HI(AHI), .DEPTH(FIFO_DEPTH)) dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_addr_sel(SEL), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
        .i_pin(pin_w), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_int(o_int),
        .o_int_oe_n(o_int_oe_n), .i_wr_hold(i_wr_hold));
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Interrupt level expected from the live compare against the snapshot
    task automatic ichk();
        repeat (8) @(posedge i_clk_sys);
        chk(o_int_oe_n, ~|(cfg_m & (in_m ^ snap)));
    endtask
    // Write n masked random bytes from command c; full buffer refuses
    task automatic wr(input logic [7:0] c, input int n, input logic [7:0] mask);
        logic [7:0] d;
        logic refuse;
        m.start();
        m.tx({AHI, SEL, 1'b0}, a);
        chk(a, 0);
        m.tx(c, a);
        chk(a, 0);
        ptr = c[2:0];
        repeat (n) begin
            d = rnd() & mask;
            refuse = i_wr_hold && fill == FIFO_DEPTH;
            m.tx(d, a);
            chk(a, refuse);
            if (!refuse) begin
                fill += i_wr_hold;
                if (ptr > 3'h1) rf[ptr] = d;
                ptr[0] = ~ptr[0];
            end
        end
        m.stop();
        repeat (4) @(posedge i_clk_sys);
    endtask
    // Read n bytes; c below zero skips the command phase
    task automatic rd(input int c, input int n);
        logic [7:0] d;
        logic [7:0] e;
        if (c >= 0) begin
            m.start();
            m.tx({AHI, SEL, 1'b0}, a);
            m.tx(c[7:0], a);
            ptr = c[2:0];
        end
        m.start();
        m.tx({AHI, SEL, 1'b1}, a);
        chk(a, 0);
        for (int i = 0; i < n; i++) begin
            e = ptr == 3'h0 ? in_m[7:0] : ptr == 3'h1 ? in_m[15:8] : rf[ptr];
            m.rx(i == n - 1, d);
            chk(d, e);
            if (ptr == 3'h0) snap[7:0] = in_m[7:0];
            if (ptr == 3'h1) snap[15:8] = in_m[15:8];
            ptr[0] = ~ptr[0];
        end
        m.stop();
        repeat (4) @(posedge i_clk_sys);
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge i_clk_sys);
        num_errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        @(posedge i_clk_sys);
        ext <= {rnd(), rnd()};
        repeat (19) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        snap = ext;
        repeat (4) @(posedge i_clk_sys);
        chk(o_pin, OUT_RST);
        chk(o_pin_oe_n, CFG_RST);
        ichk();
        rd(0, 3);
        wr(8'h03, 3, 8'hff);
        chk(o_pin, out_m);
        wr(8'h07, 2, 8'hff);
        chk(o_pin_oe_n, cfg_m);
        ichk();
        wr(8'h04, 2, 8'hff);
        rd(1, 1);
        rd(-1, 1);
        wr(8'h00, 2, 8'hff);
        rd(0, 2);
        rd(2, 4);
        wr(8'h06, 2, 8'h00);
        wr(8'h02, 2, 8'hff);
        ichk();
        wr(8'h06, 2, 8'hff);
        ichk();
        for (int k = 0; k < 6; k++) begin
            old = 16'h0001 << (rnd() & 8'h0f);
            ext <= ext ^ old;
            ichk();
            if (k % 2 == 0) begin
                ext <= ext ^ old;
            end else begin
                rd(0, 2);
            end
            ichk();
        end
        i_wr_hold <= 1'b1;
        fill = 0;
        old = out_m;
        wr(8'h02, 17, 8'hff);
        chk(o_pin, old);
        i_wr_hold <= 1'b0;
        for (int w = 0; w < 200 && o_pin !== out_m; w++) @(posedge i_clk_sys);
        chk(o_pin, out_m);
        m.start();
        m.tx({AHI, ~SEL, 1'b0}, a);
        chk(a, 1);
        m.stop();
        complete_run();
    end
endmodule // ioexp_core_bench
